//--- etdt_addr_step.sv
// address stepper: fixed, increment or decrement by the unit size, optional displacement
// assumes purely combinational use inside the controller
`timescale 1ns/1ps
`default_nettype none
module etdt_addr_step
	import etdt_pkg::*;
(
	// current address and mode
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  am,
	input  wire logic [1:0]  sz,
	input  wire logic        disp_en,
	input  wire logic [31:0] disp,
	input  wire logic        short_mode,
	// stepped address
	output logic [31:0]      next
);

	// ****************************************
	// stepping
	// ****************************************
	logic [31:0] step;
	logic [31:0] moved;

	// unit size in bytes, then direction, then displacement
	always_comb begin
		step  = 32'h0000_0001 << sz;
		moved = addr;
		if (am == AM_INC) begin
			moved = addr + step;
		end else if (am == AM_DEC) begin
			moved = addr - step;
		end
		if (disp_en) begin
			moved = moved + disp;
		end
		next = etdt_short(moved, short_mode);
	end

endmodule : etdt_addr_step
`default_nettype wire

//--- etdt_mem_model.sv
// word memory answering the controller memory port
// assumes addresses below 4 kB, right-aligned data
`timescale 1ns/1ps
`default_nettype none
module etdt_mem_model
	import etdt_pkg::*;
(
	// clock and reset
	input wire logic          clk,
	input wire logic          rst_n,
	// memory port
	input wire logic          req,
	input wire etdt_mem_req_s cmd,
	output logic              ack,
	output logic [31:0]       rdata
);
	// ****************
	// storage
	// ****************
	logic [31:0] m [0:1023];
	logic [1:0]  dly;
	logic [4:0]  sh;
	logic [9:0]  ix;
	assign sh = {cmd.addr[1:0], 3'h0};
	assign ix = cmd.addr[11:2];
	// address-dependent 0 to 3 cycle wait, idle data toggles
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (!rst_n) begin
			dly <= 2'h0;
			rdata <= 32'h0;
		end else if (req && !ack && dly != 2'h0) begin
			dly <= dly - 2'h1;
		end else if (req && !ack) begin
			ack <= 1'b1;
			dly <= cmd.addr[3:2] ^ 2'h1;
			if (!cmd.we)
				rdata <= m[ix] >> sh;
			else if (cmd.size == SZ_BYTE)
				m[ix][sh+:8] <= cmd.wdata[7:0];
			else if (cmd.size == SZ_WORD)
				m[ix][sh+:16] <= cmd.wdata[15:0];
			else
				m[ix] <= cmd.wdata;
		end
	end
endmodule : etdt_mem_model
`default_nettype wire

//--- etdt_monitor.sv
// concurrent checks on the transfer controller ports
// assumes one clock clk and a synchronous active-low rst_n
`timescale 1ns/1ps
`default_nettype none
module etdt_monitor
	import etdt_pkg::*;
#(
	parameter int NUM_SRC = 32,
	parameter int SRC_W   = 8
) (
	// clock, reset, enable
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               ce,
	// activation and memory
	input wire logic [NUM_SRC-1:0] act_req,
	input wire logic               act_ack,
	input wire logic [SRC_W-1:0]   act_ack_id,
	input wire logic               mem_req,
	input wire etdt_mem_req_s      mem_cmd,
	input wire logic               mem_ack,
	// outgoing requests
	input wire logic               cpu_irq,
	input wire logic               elc_req
);
	// ****************
	// checks
	// ****************
	logic [NUM_SRC-1:0] req_q;
	// request lines as seen at the take edge
	always_ff @(posedge clk) req_q <= act_req;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);
	a_ack_pulse: assert property (act_ack |=> !act_ack) else $error("ack too long");
	a_ack_req: assert property (act_ack |-> req_q[act_ack_id]) else $error("ack no req");
	a_ack_low: assert property (act_ack |-> (req_q & ~({NUM_SRC{1'b1}} << act_ack_id)) == '0)
		else $error("not lowest");
	a_cmd_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
		else $error("cmd moved");
	a_size_ok: assert property (mem_req |-> mem_cmd.size != 2'h3) else $error("bad size");
	a_req_drop: assert property (mem_ack |=> !mem_req) else $error("req kept");
	a_elc_pulse: assert property (elc_req |=> !elc_req) else $error("elc too long");
	a_irq_pulse: assert property (cpu_irq |=> !cpu_irq) else $error("irq too long");
	c_ack: cover property (act_ack);
	c_elc: cover property (elc_req);
	c_irq: cover property (cpu_irq);
endmodule : etdt_monitor
bind etdt_transfer_controller etdt_monitor #(.NUM_SRC(NUM_SRC), .SRC_W(SRC_W)) mon_u (.clk(clk), .rst_n(rst_n),
	.ce(ce), .act_req(act_req), .act_ack(act_ack), .act_ack_id(act_ack_id), .mem_req(mem_req), .mem_cmd(mem_cmd),
	.mem_ack(mem_ack), .cpu_irq(cpu_irq), .elc_req(elc_req));
`default_nettype wire

//--- etdt_pick.sv
// lowest-index picker over the activation request lines
// assumes requests come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module etdt_pick #(
	parameter int N = 32,
	parameter int W = 8
) (
	// requests
	input  wire logic [N-1:0] req,
	// choice
	output logic              valid,
	output logic [W-1:0]      id
);

	// ****************************************
	// priority search
	// ****************************************
	// scan downward so the lowest index wins
	always_comb begin
		valid = 1'b0;
		id    = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				valid = 1'b1;
				id    = W'(i);
			end
		end
	end

endmodule : etdt_pick
`default_nettype wire

//--- etdt_pkg.sv
// shared constants, field layouts and carrier types of the event triggered transfer controller
// assumes 32-bit AXI4-Lite register access and a 32-bit word-wide memory port
package etdt_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_VEC_BASE = 8'h00;
	localparam logic [7:0] REG_IDX_BASE = 8'h04;
	localparam logic [7:0] REG_OPR      = 8'h08;
	localparam logic [7:0] REG_SQE      = 8'h0c;
	localparam logic [7:0] REG_DISP     = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;

	// ****************************************
	// register fields and reset values
	// ****************************************
	localparam int          OPR_STOP_BIT  = 0;
	localparam int          OPR_RSKIP_BIT = 1;
	localparam int          OPR_SHORT_BIT = 2;
	localparam int          SQE_EN_BIT    = 0;
	localparam int          SQE_SRC_LSB   = 8;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [2:0]  RST_OPR       = 3'h0;
	localparam logic [7:0]  RST_SRC       = 8'h00;

	// ****************************************
	// transfer information encodings
	// ****************************************
	localparam logic [1:0]  MD_NORMAL   = 2'h0;
	localparam logic [1:0]  MD_REPEAT   = 2'h1;
	localparam logic [1:0]  MD_BLOCK    = 2'h2;
	localparam logic [1:0]  SZ_BYTE     = 2'h0;
	localparam logic [1:0]  SZ_WORD     = 2'h1;
	localparam logic [1:0]  SZ_LONG     = 2'h2;
	localparam logic [1:0]  AM_FIXED    = 2'h0;
	localparam logic [1:0]  AM_INC      = 2'h2;
	localparam logic [1:0]  AM_DEC      = 2'h3;
	localparam logic [31:0] INFO_STRIDE = 32'h0000_0010;
	localparam logic [8:0]  UNITS_MAX   = 9'h100;
	localparam logic [1:0]  AXI_OKAY    = 2'h0;
	localparam logic [1:0]  AXI_SLVERR  = 2'h2;

	// word 0 of a transfer information record
	typedef struct packed {
		logic [1:0]  md;
		logic [1:0]  sz;
		logic [1:0]  sm;
		logic [1:0]  dm;
		logic        chne;
		logic        chns;
		logic        disel;
		logic        dts;
		logic        write_back_disable_bit;
		logic        sequence_end_flag;
		logic        index_table_select;
		logic        disp_en;
		logic        act_irq;
		logic [14:0] rsvd;
	} etdt_mode_s;

	// one memory access request
	typedef struct packed {
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} etdt_mem_req_s;

	// short-address mode folds bit 23 into the top byte
	function automatic logic [31:0] etdt_short(input logic [31:0] a, input logic short_mode);
		etdt_short = short_mode ? {{8{a[23]}}, a[23:0]} : a;
	endfunction : etdt_short

endpackage : etdt_pkg

//--- etdt_transfer_controller.sv
// event triggered transfer controller: descriptor fetch, transfer, write-back, chain, sequence
// assumes an interrupt controller holding requests until acknowledged, and a memory port on clk
`timescale 1ns/1ps
`default_nettype none
module etdt_transfer_controller
	import etdt_pkg::*;
#(
	parameter int NUM_SRC = 32,
	parameter int SRC_W   = 8,
	parameter int AXI_AW  = 8
) (
	// clock, reset, enable
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	// axi4-lite register slave
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// activation requests from the interrupt controller
	input  wire logic [NUM_SRC-1:0]  act_req,
	output logic                     act_ack,
	output logic [SRC_W-1:0]         act_ack_id,
	// memory port
	output logic                     mem_req,
	output etdt_mem_req_s            mem_cmd,
	input  wire logic                mem_ack,
	input  wire logic [31:0]         mem_rdata,
	// requests to cpu and event link
	output logic                     cpu_irq,
	output logic [SRC_W-1:0]         cpu_irq_id,
	output logic                     elc_req
);

	// ****************************************
	// declarations
	// ****************************************
	typedef enum logic [2:0] {S_IDLE, S_VEC, S_INFO, S_RD, S_WR, S_WB, S_END, S_IDX} etdt_state_e;

	etdt_state_e      state;
	logic [31:0]      vec_base, idx_base, disp;
	logic [2:0]       opr;
	logic             sqe_en;
	logic [SRC_W-1:0] sqe_src;
	logic             have_aw, have_w;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             wr_fire, wr_ok, rd_ok;
	logic [31:0]      rd_mux;
	logic [SRC_W-1:0] cur_src, last_src;
	logic [31:0]      info_addr, seq_resume, sar, dar, data_hold;
	etdt_mode_s       mode;
	logic [15:0]      cra, crb;
	logic [8:0]       blk_left;
	logic [1:0]       word_k;
	logic [7:0]       idx_sel;
	logic             idx_pending, in_seq, seq_susp, chained, last_valid, count_end;
	logic             pick_valid;
	logic [SRC_W-1:0] pick_id;
	logic [31:0]      sar_next, dar_next, span, sar_new, dar_new;
	logic             seq_hit, rpt_wrap, end_now, idx_now;
	logic [31:0]      rd_data;

	function automatic logic [8:0] units(input logic [7:0] r);
		units = (r == 8'h00) ? UNITS_MAX : {1'b0, r};
	endfunction : units

	function automatic logic [31:0] back(input logic [31:0] a, input logic [1:0] am, input logic [31:0] s);
		back = (am == AM_INC) ? a - s : (am == AM_DEC) ? a + s : a;
	endfunction : back

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				o[8*b +: 8] = n[8*b +: 8];
			end
		end
		wmerge = o;
	endfunction : wmerge

	// ****************************************
	// helpers
	// ****************************************
	etdt_pick #(.N(NUM_SRC), .W(SRC_W)) u_pick (
		.req   (act_req),
		.valid (pick_valid),
		.id    (pick_id)
	);

	etdt_addr_step u_src_step (
		.addr       (sar),
		.am         (mode.sm),
		.sz         (mode.sz),
		.disp_en    (mode.disp_en),
		.disp       (disp),
		.short_mode (opr[OPR_SHORT_BIT]),
		.next       (sar_next)
	);

	etdt_addr_step u_dst_step (
		.addr       (dar),
		.am         (mode.dm),
		.sz         (mode.sz),
		.disp_en    (1'b0),
		.disp       (RST_WORD),
		.short_mode (opr[OPR_SHORT_BIT]),
		.next       (dar_next)
	);

	// unit bookkeeping for the unit now being written
	always_comb begin
		seq_hit  = sqe_en && (cur_src == sqe_src);
		span     = {23'h0, units(cra[15:8])} << mode.sz;
		rpt_wrap = ((mode.md == MD_REPEAT) && (cra[7:0] == 8'h01)) ||
		           ((mode.md == MD_BLOCK) && (blk_left == 9'h001));
		sar_new  = (rpt_wrap && mode.dts) ? back(sar_next, mode.sm, span) : sar_next;
		dar_new  = (rpt_wrap && !mode.dts) ? back(dar_next, mode.dm, span) : dar_next;
		end_now  = ((mode.md == MD_NORMAL) && (cra == 16'h0001)) ||
		           ((mode.md == MD_BLOCK) && (blk_left == 9'h001) && (crb == 16'h0001));
		idx_now  = mode.index_table_select && seq_hit;
		case (mode.sz)
			SZ_BYTE: rd_data = {24'h0, mem_rdata[7:0]};
			SZ_WORD: rd_data = {16'h0, mem_rdata[15:0]};
			default: rd_data = mem_rdata;
		endcase
	end

	// ****************************************
	// register bus
	// ****************************************
	assign wr_fire = have_aw && have_w && !s_axi_bvalid;

	// write address and data may arrive in either order
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			have_aw       <= 1'b0;
			have_w        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= RST_WORD;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AXI_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!have_aw && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!have_w && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				have_aw      <= 1'b0;
				have_w       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vec_base <= RST_WORD;
			idx_base <= RST_WORD;
			disp     <= RST_WORD;
			opr      <= RST_OPR;
			sqe_en   <= 1'b0;
			sqe_src  <= RST_SRC;
		end else if (ce && wr_fire) begin
			case (aw_addr[7:0])
				REG_VEC_BASE: vec_base <= wmerge(vec_base, w_data, w_strb);
				REG_IDX_BASE: idx_base <= wmerge(idx_base, w_data, w_strb);
				REG_DISP:     disp     <= wmerge(disp, w_data, w_strb);
				REG_OPR: begin
					if (w_strb[0]) begin
						opr <= w_data[2:0];
					end
				end
				REG_SQE: begin
					if (w_strb[0]) begin
						sqe_en <= w_data[SQE_EN_BIT];
					end
					if (w_strb[1]) begin
						sqe_src <= w_data[SQE_SRC_LSB +: SRC_W];
					end
				end
				default: ;
			endcase
		end
	end

	// read mux and decode
	always_comb begin
		wr_ok  = (aw_addr[7:0] <= REG_DISP) && (aw_addr[1:0] == 2'h0);
		rd_ok  = 1'b1;
		rd_mux = RST_WORD;
		case (s_axi_araddr[7:0])
			REG_VEC_BASE: rd_mux = vec_base;
			REG_IDX_BASE: rd_mux = idx_base;
			REG_OPR:      rd_mux = {29'h0, opr};
			REG_SQE:      rd_mux = {16'h0, sqe_src, 7'h0, sqe_en};
			REG_DISP:     rd_mux = disp;
			REG_STATUS:   rd_mux = {16'h0, cur_src, 6'h0, seq_susp, state != S_IDLE};
			default:      rd_ok  = 1'b0;
		endcase
	end

	// one read at a time, answered the cycle after acceptance
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= RST_WORD;
			s_axi_rresp   <= AXI_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// transfer engine
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state       <= S_IDLE;
			mem_req     <= 1'b0;
			mem_cmd     <= '0;
			act_ack     <= 1'b0;
			act_ack_id  <= RST_SRC;
			cpu_irq     <= 1'b0;
			cpu_irq_id  <= RST_SRC;
			elc_req     <= 1'b0;
			cur_src     <= RST_SRC;
			last_src    <= RST_SRC;
			info_addr   <= RST_WORD;
			seq_resume  <= RST_WORD;
			sar         <= RST_WORD;
			dar         <= RST_WORD;
			data_hold   <= RST_WORD;
			mode        <= '0;
			cra         <= 16'h0;
			crb         <= 16'h0;
			blk_left    <= 9'h0;
			word_k      <= 2'h0;
			idx_sel     <= 8'h0;
			idx_pending <= 1'b0;
			in_seq      <= 1'b0;
			seq_susp    <= 1'b0;
			chained     <= 1'b0;
			last_valid  <= 1'b0;
			count_end   <= 1'b0;
		end else if (ce) begin
			act_ack <= 1'b0;
			cpu_irq <= 1'b0;
			elc_req <= 1'b0;
			if (wr_fire && (aw_addr[7:0] == REG_VEC_BASE)) begin
				last_valid <= 1'b0;
			end
			if (wr_fire && (aw_addr[7:0] == REG_SQE)) begin
				seq_susp <= 1'b0;
			end
			case (state)
				S_IDLE: begin
					// a stopped module starts nothing and keeps every register
					if (!opr[OPR_STOP_BIT] && pick_valid) begin
						cur_src    <= pick_id;
						act_ack    <= 1'b1;
						act_ack_id <= pick_id;
						chained    <= 1'b0;
						word_k     <= 2'h0;
						if (sqe_en && (pick_id == sqe_src) && seq_susp) begin
							in_seq    <= 1'b1;
							info_addr <= seq_resume;
							state     <= S_INFO;
						end else if (opr[OPR_RSKIP_BIT] && last_valid && (pick_id == last_src)) begin
							blk_left <= (mode.md == MD_BLOCK) ? units(cra[15:8]) : 9'h001;
							state    <= S_RD;
							if (mode.act_irq) begin
								cpu_irq    <= 1'b1;
								cpu_irq_id <= pick_id;
							end
						end else begin
							state <= S_VEC;
						end
					end
				end
				S_VEC: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b0, size: SZ_LONG, addr: vec_base + {cur_src, 2'h0}, wdata: RST_WORD};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						info_addr <= mem_rdata;
						state     <= S_INFO;
					end
				end
				S_INFO: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b0, size: SZ_LONG, addr: info_addr + {word_k, 2'h0}, wdata: RST_WORD};
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						word_k  <= word_k + 2'h1;
						case (word_k)
							2'h0: mode <= mem_rdata;
							2'h1: sar  <= etdt_short(mem_rdata, opr[OPR_SHORT_BIT]);
							2'h2: dar  <= etdt_short(mem_rdata, opr[OPR_SHORT_BIT]);
							default: begin
								cra      <= mem_rdata[31:16];
								crb      <= mem_rdata[15:0];
								blk_left <= (mode.md == MD_BLOCK) ? units(mem_rdata[31:24]) : 9'h001;
								state    <= S_RD;
								if (mode.act_irq) begin
									cpu_irq    <= 1'b1;
									cpu_irq_id <= cur_src;
								end
							end
						endcase
					end
				end
				S_RD: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b0, size: mode.sz, addr: sar, wdata: RST_WORD};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						data_hold <= rd_data;
						state     <= S_WR;
					end
				end
				S_WR: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b1, size: mode.sz, addr: dar, wdata: data_hold};
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						sar     <= sar_new;
						dar     <= dar_new;
						if (idx_now) begin
							idx_pending <= 1'b1;
							idx_sel     <= data_hold[7:0];
						end
						if (mode.md == MD_BLOCK) begin
							blk_left <= blk_left - 9'h001;
							if (blk_left == 9'h001) begin
								crb <= crb - 16'h0001;
								cra <= {cra[15:8], cra[15:8]};
							end
						end else if (mode.md == MD_REPEAT) begin
							cra <= rpt_wrap ? {cra[15:8], cra[15:8]} : {cra[15:8], cra[7:0] - 8'h01};
						end else begin
							cra <= cra - 16'h0001;
						end
						if ((mode.md != MD_BLOCK) || (blk_left == 9'h001)) begin
							// one unit, or one whole block, is done for this activation
							elc_req   <= 1'b1;
							count_end <= end_now;
							word_k    <= 2'h1;
							state     <= mode.write_back_disable_bit ? S_END : S_WB;
							if (mode.disel || end_now) begin
								cpu_irq    <= 1'b1;
								cpu_irq_id <= cur_src;
							end
						end else begin
							state <= S_RD;
						end
					end
				end
				S_WB: begin
					if (!mem_req) begin
						if ((word_k == 2'h1) && (mode.sm == AM_FIXED)) begin
							word_k <= 2'h2;
						end else if ((word_k == 2'h2) && (mode.dm == AM_FIXED)) begin
							word_k <= 2'h3;
						end else begin
							mem_req <= 1'b1;
							mem_cmd <= '{we: 1'b1, size: SZ_LONG, addr: info_addr + {word_k, 2'h0},
							             wdata: (word_k == 2'h1) ? sar : (word_k == 2'h2) ? dar : {cra, crb}};
						end
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						word_k  <= word_k + 2'h1;
						if (word_k == 2'h3) begin
							state <= S_END;
						end
					end
				end
				S_END: begin
					word_k <= 2'h0;
					if (idx_pending) begin
						idx_pending <= 1'b0;
						in_seq      <= 1'b1;
						chained     <= 1'b1;
						state       <= S_IDX;
					end else if (in_seq && mode.sequence_end_flag) begin
						in_seq   <= 1'b0;
						seq_susp <= 1'b0;
						state    <= S_IDLE;
					end else if (mode.chne && (!mode.chns || count_end)) begin
						info_addr <= info_addr + INFO_STRIDE;
						chained   <= 1'b1;
						state     <= S_INFO;
					end else begin
						// a sequence ending without its end flag is suspended here
						if (in_seq) begin
							seq_susp   <= 1'b1;
							seq_resume <= info_addr + INFO_STRIDE;
						end
						in_seq     <= 1'b0;
						last_src   <= cur_src;
						last_valid <= !chained && !in_seq;
						state      <= S_IDLE;
					end
				end
				S_IDX: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b0, size: SZ_LONG, addr: idx_base + {22'h0, idx_sel, 2'h0}, wdata: RST_WORD};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						info_addr <= mem_rdata;
						state     <= S_INFO;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule : etdt_transfer_controller
`default_nettype wire

//--- etdt_transfer_controller_tb_top.sv
// bench: registers, normal, block and repeat transfers, read skip, clock enable, module stop
// assumes etdt_mem_model on the memory port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, a); end end
module etdt_transfer_controller_tb_top
	import etdt_pkg::*;
;
	logic	clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, ce_r = 1'b1;
	logic [7:0]	awaddr = 8'h00, araddr = 8'h00, id_q, iid_q;
	logic [31:0]	wdata = 32'h0, act = 32'h0, rd;
	logic [1:0]	rsp;
	wire logic	awready, wready, bvalid, arready, rvalid, act_ack, mem_req, mem_ack, cpu_irq, elc_req;
	wire logic [1:0]	bresp, rresp;
	wire logic [31:0]	rdata, mem_rdata;
	wire logic [7:0]	ack_id, irq_id;
	wire etdt_mem_req_s	mem_cmd;
	int	error_cnt = 0, total_checks = 0, n_elc = 0, n_irq = 0, n_ack = 0;
	// ****************
	// clock, counters, parts
	// ****************
	always #12.5 clk = ~clk;
	// pulse counts and last source taken
	always @(posedge clk) begin
		n_elc += elc_req;
		n_irq += cpu_irq;
		n_ack += act_ack;
		if (act_ack) id_q <= ack_id;
		if (cpu_irq) iid_q <= irq_id;
	end
	etdt_transfer_controller dut_u (.clk(clk), .rst_n(rst_n), .ce(ce_r), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.act_req(act), .act_ack(act_ack), .act_ack_id(ack_id), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .cpu_irq(cpu_irq), .cpu_irq_id(irq_id), .elc_req(elc_req));
	etdt_mem_model mem_u (.clk(clk), .rst_n(rst_n), .req(mem_req), .cmd(mem_cmd), .ack(mem_ack), .rdata(mem_rdata));
	// register write, each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awv <= 1'b0;
			if (wready) wv <= 1'b0;
			if (bvalid) break;
		end
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr
	// register read
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arv <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rdr
	// raise a source until taken, then wait for idle
	task automatic fire(input int s);
		@(posedge clk);
		act[s] <= 1'b1;
		for (int i = 0; i < 40 && !act_ack; i++) @(posedge clk);
		act[s] <= 1'b0;
		rd = 32'h1;
		for (int i = 0; i < 60 && rd[0] !== 1'b0; i++) rdr(REG_STATUS);
	endtask : fire
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// watchdog
	initial begin
		repeat (8000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	// test sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rdr(REG_OPR);
		`CHK("opr reset", 32'h0, rd)
		wr(REG_DISP, 32'h10);
		rdr(REG_DISP);
		`CHK("disp", 32'h10, rd)
		rdr(8'h20);
		`CHK("unmapped", AXI_SLVERR, rsp)
		$display("registers done");
		wr(REG_VEC_BASE, 32'h100);
		mem_u.m['h43] = 32'h200;
		mem_u.m['h80] = 32'h2a21_0000;
		mem_u.m['h81] = 32'h400;
		mem_u.m['h82] = 32'h500;
		mem_u.m['h83] = 32'h0001_0000;
		mem_u.m['h100] = 32'h1234_5678;
		fire(3);
		`CHK("src", 8'h03, id_q)
		`CHK("dst", 32'h1234_5678, mem_u.m['h140])
		`CHK("sar back", 32'h414, mem_u.m['h81])
		`CHK("dar back", 32'h504, mem_u.m['h82])
		`CHK("count back", 32'h0, mem_u.m['h83])
		`CHK("elc", 1, n_elc)
		`CHK("irq", 1, n_irq)
		$display("normal done");
		mem_u.m['h45] = 32'h300;
		mem_u.m['hc0] = 32'h8a08_0000;
		mem_u.m['hc1] = 32'h600;
		mem_u.m['hc2] = 32'h700;
		mem_u.m['hc3] = 32'h0202_0001;
		mem_u.m['h180] = 32'haabb_ccdd;
		mem_u.m['h1c0] = 32'h0;
		fire(5);
		`CHK("block dst", 32'h0000_ccdd, mem_u.m['h1c0])
		`CHK("no wb", 32'h600, mem_u.m['hc1])
		`CHK("block elc", 2, n_elc)
		`CHK("block irq", 2, n_irq)
		$display("block done");
		wr(REG_OPR, 32'h1);
		act[5] <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("stopped", 2, n_ack)
		act[5] <= 1'b0;
		rdr(REG_OPR);
		`CHK("opr kept", 32'h1, rd)
		$display("stop done");
		wr(REG_OPR, 32'h2);
		wr(8'h20, 32'h1);
		`CHK("wr unmapped", AXI_SLVERR, rsp)
		mem_u.m['h46] = 32'h380;
		mem_u.m['he0] = 32'h6200_8000;
		mem_u.m['he1] = 32'h800;
		mem_u.m['he2] = 32'h900;
		mem_u.m['he3] = 32'h0202_0000;
		mem_u.m['h200] = 32'h1111_2222;
		fire(6);
		`CHK("irq src", 8'h06, iid_q)
		`CHK("rpt dst", 32'h1111_2222, mem_u.m['h240])
		`CHK("rpt count", 32'h0201_0000, mem_u.m['he3])
		mem_u.m['he1] = 32'ha00;
		mem_u.m['he2] = 32'ha00;
		mem_u.m['h200] = 32'h3333_4444;
		ce_r <= 1'b0;
		act[6] <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK("frozen", 3, n_ack)
		ce_r <= 1'b1;
		act[6] <= 1'b0;
		fire(6);
		`CHK("skip read", 32'h3333_4444, mem_u.m['h241])
		`CHK("fixed no wb", 32'ha00, mem_u.m['he1])
		`CHK("rpt reload", 32'h900, mem_u.m['he2])
		`CHK("act irq", 4, n_irq)
		`CHK("rpt elc", 4, n_elc)
		$display("repeat done");
		summarize();
	end
endmodule : etdt_transfer_controller_tb_top
`default_nettype wire
